// ---- rtl/vel_layout_top.sv ----
// vel_layout_top: vector register file with element-indexed access
// assumes requests come from logic on mclk; strobes are one cycle, one at a time
//
// The register addresses and the plain strobed port were left to the implementer.
module vel_layout_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // request strobes
   input wire logic reqWrite,
   input wire logic reqRead,
   input wire logic reqTail,
   // request fields
   input wire logic [vel_pkg::REG_NUM_BITS-1:0] reqBase,
   input wire logic [vel_pkg::INDEX_BITS-1:0] reqIndex,
   input wire logic [vel_pkg::ELEM_MAX_BITS-1:0] reqWrData,
   // operating point
   input wire logic [1:0] elementWidth,
   input wire logic [2:0] groupFactor,
   input wire logic tailAgnostic,
   // answers
   output logic rdValid,
   output logic [vel_pkg::ELEM_MAX_BITS-1:0] rdData,
   output logic rdActive,
   output logic reqError,
   output logic wrDone
);
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [vel_pkg::REGISTER_BIT_LENGTH-1:0] vrf [0:vel_pkg::REG_COUNT-1];

   logic [vel_pkg::REG_NUM_BITS-1:0] regNum;
   logic [vel_pkg::REG_BYTE_SHIFT-1:0] byteOff;
   logic [vel_pkg::REG_BYTES-1:0] laneMask;
   logic [vel_pkg::REG_BYTES-1:0] activeLanes;
   logic elemActive;
   logic fractional;
   logic mapError;

   logic [vel_pkg::REGISTER_BIT_LENGTH-1:0] curRow;
   logic [vel_pkg::REGISTER_BIT_LENGTH-1:0] shiftedData;
   logic [vel_pkg::REGISTER_BIT_LENGTH-1:0] next_row;
   logic [vel_pkg::REGISTER_BIT_LENGTH-1:0] alignedRow;
   logic [3:0] elemByteCount;
   logic [vel_pkg::ELEM_MAX_BITS-1:0] next_rdData;
   logic [vel_pkg::REG_NUM_BITS-1:0] rowSel;
   logic doWrite;
   logic doTail;
   logic tailFill;
   logic rowWrite;
   logic badReq;
   logic rdAccept;

   // ------------------------------------------------------------
   // index to location map
   // ------------------------------------------------------------
   vel_addr_map vel_addr_map_inst (
      .baseReg(reqBase),
      .elemIndex(reqIndex),
      .elementWidth(elementWidth),
      .groupFactor(groupFactor),
      .regNum(regNum),
      .byteOff(byteOff),
      .laneMask(laneMask),
      .activeLanes(activeLanes),
      .elemActive(elemActive),
      .fractional(fractional),
      .mapError(mapError)
   );

   // ------------------------------------------------------------
   // row selection
   // ------------------------------------------------------------
   always_comb begin
      // a tail request acts on the named register, whatever the index
      rowSel = reqTail ? reqBase : regNum;
      curRow = vrf[rowSel];
   end

   // ------------------------------------------------------------
   // request qualification
   // ------------------------------------------------------------
   always_comb begin
      rdAccept = reqRead && !mapError;
      // a misaligned group base or a register past the file is refused
      badReq = ((reqWrite || reqRead) && mapError) ||
               (reqTail && mapError && !fractional);
      // only active slots take element writes
      doWrite = reqWrite && !mapError && elemActive;
      // a fractional tail never fails on its index
      doTail = reqTail && fractional;
      tailFill = doTail && tailAgnostic;
      rowWrite = doWrite || tailFill;
   end

   // ------------------------------------------------------------
   // write data alignment: element low byte to slot low lane
   // ------------------------------------------------------------
   always_comb begin
      shiftedData = vel_pkg::REGISTER_BIT_LENGTH'(
         {{(vel_pkg::REGISTER_BIT_LENGTH-vel_pkg::ELEM_MAX_BITS){1'b0}}, reqWrData}
         << {byteOff, 3'h0});
   end

   // ------------------------------------------------------------
   // per-lane merge of new row
   // ------------------------------------------------------------
   genvar lane;
   generate
      for (lane = 0; lane < vel_pkg::REG_BYTES; lane++) begin : gLane
         always_comb begin
            if (doWrite && laneMask[lane]) begin
               next_row[lane*8 +: 8] = shiftedData[lane*8 +: 8];
            end else if (tailFill && !activeLanes[lane]) begin
               next_row[lane*8 +: 8] = vel_pkg::TAIL_FILL_BYTE;
            end else begin
               next_row[lane*8 +: 8] = curRow[lane*8 +: 8];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // register file update (contents undefined after reset)
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rowWrite) begin
         vrf[rowSel] <= next_row;
      end
   end

   // ------------------------------------------------------------
   // read extraction: slot to low bits, zero above width
   // ------------------------------------------------------------
   always_comb begin
      alignedRow = curRow >> {byteOff, 3'h0};
      elemByteCount = 4'(4'h1 << elementWidth);
   end

   // ------------------------------------------------------------
   // per-byte zero extension above the element width
   // ------------------------------------------------------------
   genvar rdByte;
   generate
      for (rdByte = 0; rdByte < vel_pkg::ELEM_MAX_BITS / 8; rdByte++) begin : gRdByte
         always_comb begin
            if (4'(rdByte) < elemByteCount) begin
               next_rdData[rdByte*8 +: 8] = alignedRow[rdByte*8 +: 8];
            end else begin
               next_rdData[rdByte*8 +: 8] = 8'h0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // read answer pulse
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdValid <= 1'b0;
      end else begin
         rdValid <= rdAccept;
      end
   end

   // ------------------------------------------------------------
   // read data, held until the next accepted read
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdData <= vel_pkg::RD_DATA_RESET;
      end else if (rdAccept) begin
         rdData <= next_rdData;
      end
   end

   // ------------------------------------------------------------
   // active-slot flag of the last accepted read
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdActive <= 1'b0;
      end else if (rdAccept) begin
         rdActive <= elemActive;
      end
   end

   // ------------------------------------------------------------
   // refusal pulse
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         reqError <= 1'b0;
      end else begin
         reqError <= badReq || (reqWrite && !mapError && !elemActive);
      end
   end

   // ------------------------------------------------------------
   // completion pulse
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         wrDone <= 1'b0;
      end else begin
         wrDone <= doWrite || doTail;
      end
   end

endmodule : vel_layout_top

// ---- rtl/vel_pkg.sv ----
// vel_pkg: shared constants for the vector element layout block
// assumes a single core clock domain and one vector register file instance
package vel_pkg;
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // register file geometry
   // ------------------------------------------------------------
   localparam int REGISTER_BIT_LENGTH = 128;
   localparam int REG_BYTES = REGISTER_BIT_LENGTH / 8;
   localparam int REG_BYTE_SHIFT = 4;
   localparam int REG_COUNT = 32;
   localparam int REG_NUM_BITS = 5;
   localparam int ELEM_MAX_BITS = 64;
   localparam int INDEX_BITS = 8;
   localparam int BYTE_ADDR_BITS = 11;

   // ------------------------------------------------------------
   // element width codes (bytes = 1 << code)
   // ------------------------------------------------------------
   localparam logic [1:0] EW_8 = 2'h0;
   localparam logic [1:0] EW_16 = 2'h1;
   localparam logic [1:0] EW_32 = 2'h2;
   localparam logic [1:0] EW_64 = 2'h3;

   // ------------------------------------------------------------
   // group factor codes: 0..3 = 1,2,4,8; 5,6,7 = 1/8,1/4,1/2
   // ------------------------------------------------------------
   localparam logic [2:0] GF_1 = 3'h0;
   localparam logic [2:0] GF_2 = 3'h1;
   localparam logic [2:0] GF_4 = 3'h2;
   localparam logic [2:0] GF_8 = 3'h3;
   localparam logic [2:0] GF_RESERVED = 3'h4;
   localparam logic [2:0] GF_EIGHTH = 3'h5;
   localparam logic [2:0] GF_QUARTER = 3'h6;
   localparam logic [2:0] GF_HALF = 3'h7;
   localparam logic [2:0] GF_FRAC_BASE = 3'h0;

   // ------------------------------------------------------------
   // tail fill and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] TAIL_FILL_BYTE = 8'hff;
   localparam logic [ELEM_MAX_BITS-1:0] RD_DATA_RESET = 64'h0;

endpackage : vel_pkg

// ---- rtl/vel_addr_map.sv ----
// vel_addr_map: combinational map from element index to register and byte lanes
// assumes codes from vel_pkg; no state, no clock
module vel_addr_map (
   // element selection
   input wire logic [vel_pkg::REG_NUM_BITS-1:0] baseReg,
   input wire logic [vel_pkg::INDEX_BITS-1:0] elemIndex,
   input wire logic [1:0] elementWidth,
   input wire logic [2:0] groupFactor,
   // mapped location
   output logic [vel_pkg::REG_NUM_BITS-1:0] regNum,
   output logic [vel_pkg::REG_BYTE_SHIFT-1:0] byteOff,
   output logic [vel_pkg::REG_BYTES-1:0] laneMask,
   output logic [vel_pkg::REG_BYTES-1:0] activeLanes,
   output logic elemActive,
   output logic fractional,
   output logic mapError
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [vel_pkg::BYTE_ADDR_BITS-1:0] byteAddr;
   logic [6:0] regOff;
   logic [7:0] regSum;
   logic [3:0] groupRegs;
   logic [9:0] vlmaxBytes;
   logic [9:0] vlmax;
   logic [4:0] elemBytes;
   logic baseBad;

   always_comb begin
      fractional = groupFactor > vel_pkg::GF_RESERVED;
      // slots run upward from the low end, register after register
      byteAddr = vel_pkg::BYTE_ADDR_BITS'({3'h0, elemIndex} << elementWidth);
      regOff = byteAddr[vel_pkg::BYTE_ADDR_BITS-1:vel_pkg::REG_BYTE_SHIFT];
      byteOff = byteAddr[vel_pkg::REG_BYTE_SHIFT-1:0];
      regSum = 8'(baseReg) + 8'(regOff);
      regNum = regSum[vel_pkg::REG_NUM_BITS-1:0];
      groupRegs = fractional ? 4'h1 : 4'(4'h1 << groupFactor[1:0]);
      if (fractional) begin
         vlmaxBytes = 10'(10'(vel_pkg::REG_BYTES) >> (4'h8 - 4'(groupFactor)));
      end else begin
         vlmaxBytes = 10'(10'(vel_pkg::REG_BYTES) << groupFactor[1:0]);
      end
      vlmax = vlmaxBytes >> elementWidth;
      elemActive = 10'(elemIndex) < vlmax;
      elemBytes = 5'(5'h1 << elementWidth);
      // lowest byte of the element sits at the lowest lane of its slot
      laneMask = vel_pkg::REG_BYTES'((17'h1 << elemBytes) - 17'h1) << byteOff;
      activeLanes = fractional ? vel_pkg::REG_BYTES'((17'h1 << vlmaxBytes[4:0]) - 17'h1)
                               : {vel_pkg::REG_BYTES{1'b1}};
      baseBad = (4'(baseReg[3:0]) & (groupRegs - 4'h1)) != 4'h0;
      mapError = baseBad || (regSum >= 8'(vel_pkg::REG_COUNT)) ||
                 (groupFactor == vel_pkg::GF_RESERVED);
   end

endmodule : vel_addr_map

// ---- testbench/vel_layout_assertions.sv ----
// vel_layout_assertions: port checks on vel_layout_top
// assumes one strobe per cycle from the requesting datapath
module vel_layout_assertions (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // requests
   input wire logic reqWrite,
   input wire logic reqRead,
   input wire logic reqTail,
   input wire logic [vel_pkg::REG_NUM_BITS-1:0] reqBase,
   input wire logic [vel_pkg::INDEX_BITS-1:0] reqIndex,
   input wire logic [vel_pkg::ELEM_MAX_BITS-1:0] reqWrData,
   input wire logic [1:0] elementWidth,
   input wire logic [2:0] groupFactor,
   input wire logic tailAgnostic,
   // answers
   input wire logic rdValid,
   input wire logic [vel_pkg::ELEM_MAX_BITS-1:0] rdData,
   input wire logic rdActive,
   input wire logic reqError,
   input wire logic wrDone
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] capOne;
   logic bad;
   logic one;
   assign capOne = 8'h10 >> elementWidth;
   assign bad = (groupFactor < 3'h4) && ((reqBase & ((5'h1 << groupFactor) - 5'h1)) != 5'h0);
   assign one = groupFactor == vel_pkg::GF_1;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   a_reserved_refused: assert property ((reqRead || reqWrite) && groupFactor == 3'h4
      |=> reqError && !wrDone && !rdValid) else $error("reserved factor not refused");
   a_misalign_refused: assert property ((reqRead || reqWrite) && bad
      |=> reqError && !wrDone && !rdValid) else $error("misaligned base not refused");
   a_write_taken: assert property (reqWrite && one && reqIndex < capOne
      |=> wrDone && !reqError) else $error("write not taken");
   a_write_beyond: assert property (reqWrite && one && reqIndex >= capOne
      |=> reqError && !wrDone) else $error("write beyond capacity taken");
   a_read_active: assert property (reqRead && one && reqIndex < capOne
      |=> rdValid && rdActive) else $error("active read wrong");
   a_tail_quiet: assert property (reqTail && groupFactor < 3'h4 && !bad
      |=> !wrDone && !reqError) else $error("tail on whole group acted");
   a_tail_done: assert property (reqTail && groupFactor > 3'h4
      |=> wrDone && !reqError) else $error("fractional tail not done");
   a_data_holds: assert property (!rdValid |-> $stable(rdData))
      else $error("read data moved without read");
   a_valid_cause: assert property (rdValid |-> $past(reqRead))
      else $error("read answer without read");
   cover property (reqTail && tailAgnostic ##1 wrDone);
   cover property (reqWrite ##1 reqError);
   cover property (reqRead && groupFactor == vel_pkg::GF_2 ##1 rdValid);
endmodule : vel_layout_assertions

bind vel_layout_top vel_layout_assertions vel_layout_assertions_inst (.mclk(mclk), .rst(rst),
   .reqWrite(reqWrite), .reqRead(reqRead), .reqTail(reqTail), .reqBase(reqBase),
   .reqIndex(reqIndex), .reqWrData(reqWrData), .elementWidth(elementWidth),
   .groupFactor(groupFactor), .tailAgnostic(tailAgnostic), .rdValid(rdValid),
   .rdData(rdData), .rdActive(rdActive), .reqError(reqError), .wrDone(wrDone));

// ---- testbench/vel_datapath_model.sv ----
// vel_datapath_model: requesting datapath, one strobe per call
// assumes answers one cycle after the strobe
module vel_datapath_model (
   input wire logic mclk,
   output logic reqWrite = 1'b0,
   output logic reqRead = 1'b0,
   output logic reqTail = 1'b0,
   output logic [4:0] reqBase = 5'h0,
   output logic [7:0] reqIndex = 8'h0,
   output logic [63:0] reqWrData = 64'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   // k = {tail, read, write}; fields scrambled once released
   task automatic op(input logic [2:0] k, input logic [4:0] b, input logic [7:0] i,
                     input logic [63:0] d);
      @(posedge mclk);
      {reqTail, reqRead, reqWrite} <= k;
      reqBase <= b;
      reqIndex <= i;
      reqWrData <= d;
      @(posedge mclk);
      {reqTail, reqRead, reqWrite} <= 3'h0;
      reqBase <= ~b;
      reqIndex <= ~i;
      reqWrData <= ~d;
      #1;
   endtask : op
endmodule : vel_datapath_model

// ---- testbench/tb_vel_layout_top.sv ----
// tb_vel_layout_top: self-checking bench for the element layout block
// assumes vel_pkg, the datapath model and the checker are compiled first
`define CHK(n, e, s) begin \
   total_checks++; \
   if ((s) !== (e)) begin \
      error_cnt++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, s); \
   end \
end
module tb_vel_layout_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] ew = 2'h0;
   logic [2:0] gf = 3'h0;
   logic ta = 1'b0;
   logic reqWrite, reqRead, reqTail, rdValid, rdActive, reqError, wrDone;
   logic [4:0] reqBase;
   logic [7:0] reqIndex;
   logic [63:0] reqWrData, rdData;
   int error_cnt = 0;
   int total_checks = 0;
   vel_datapath_model vel_datapath_model_inst (.mclk(mclk), .reqWrite(reqWrite),
      .reqRead(reqRead), .reqTail(reqTail), .reqBase(reqBase), .reqIndex(reqIndex),
      .reqWrData(reqWrData));
   vel_layout_top vel_layout_top_inst (.mclk(mclk), .rst(rst), .reqWrite(reqWrite),
      .reqRead(reqRead), .reqTail(reqTail), .reqBase(reqBase), .reqIndex(reqIndex),
      .reqWrData(reqWrData), .elementWidth(ew), .groupFactor(gf), .tailAgnostic(ta),
      .rdValid(rdValid), .rdData(rdData), .rdActive(rdActive), .reqError(reqError),
      .wrDone(wrDone));
   always #20 mclk = ~mclk;
   task automatic mode(input logic [1:0] w, input logic [2:0] g, input logic t);
      @(posedge mclk);
      ew <= w;
      gf <= g;
      ta <= t;
   endtask : mode
   task automatic wr(input logic [4:0] b, input logic [7:0] i, input logic [63:0] d);
      vel_datapath_model_inst.op(3'h1, b, i, d);
   endtask : wr
   task automatic rdchk(string n, input logic [4:0] b, input logic [7:0] i,
                        input logic [63:0] e, input logic act);
      vel_datapath_model_inst.op(3'h2, b, i, 64'h0);
      `CHK(n, 1'b1, rdValid)
      `CHK(n, e, rdData)
      `CHK(n, act, rdActive)
   endtask : rdchk
   task automatic t_single();
      mode(vel_pkg::EW_16, vel_pkg::GF_1, 1'b0);
      for (int i = 0; i < 8; i++) begin
         wr(5'h0, 8'(i), {48'hbeef_beef_beef, 8'h81, 8'(i)});
         `CHK("wrDone", 1'b1, wrDone)
      end
      wr(5'h0, 8'h8, 64'h0);
      `CHK("beyond", 1'b1, reqError)
      mode(vel_pkg::EW_8, vel_pkg::GF_1, 1'b0);
      for (int i = 0; i < 8; i++) begin
         rdchk("byteLow", 5'h0, 8'(2 * i), 64'(i), 1'b1);
         rdchk("byteHigh", 5'h0, 8'(2 * i + 1), 64'h81, 1'b1);
      end
      mode(vel_pkg::EW_64, vel_pkg::GF_1, 1'b0);
      rdchk("wide", 5'h0, 8'h0, 64'h8103_8102_8101_8100, 1'b1);
      rdchk("wideHi", 5'h0, 8'h1, 64'h8107_8106_8105_8104, 1'b1);
   endtask : t_single
   task automatic t_group();
      mode(vel_pkg::EW_32, vel_pkg::GF_2, 1'b0);
      for (int i = 0; i < 8; i++) wr(5'h2, 8'(i), 64'h5a00 + 64'(i));
      rdchk("grpRead", 5'h2, 8'h5, 64'h5a05, 1'b1);
      wr(5'h3, 8'h0, 64'h0);
      `CHK("misalign", 1'b1, reqError)
      mode(vel_pkg::EW_32, vel_pkg::GF_1, 1'b0);
      for (int i = 0; i < 8; i++) begin
         rdchk("grpFill", 5'(2 + i / 4), 8'(i % 4), 64'h5a00 + 64'(i), 1'b1);
      end
      mode(vel_pkg::EW_8, vel_pkg::GF_RESERVED, 1'b0);
      wr(5'h0, 8'h0, 64'h0);
      `CHK("reserved", 1'b1, reqError)
   endtask : t_group
   task automatic t_frac();
      mode(vel_pkg::EW_8, vel_pkg::GF_1, 1'b0);
      for (int i = 0; i < 16; i++) wr(5'h4, 8'(i), 64'h40 + 64'(i));
      mode(vel_pkg::EW_8, vel_pkg::GF_QUARTER, 1'b0);
      vel_datapath_model_inst.op(3'h4, 5'h4, 8'h0, 64'h0);
      `CHK("tailDone", 1'b1, wrDone)
      rdchk("tailKept", 5'h4, 8'h4, 64'h44, 1'b0);
      rdchk("active", 5'h4, 8'h3, 64'h43, 1'b1);
      mode(vel_pkg::EW_8, vel_pkg::GF_QUARTER, 1'b1);
      wr(5'h4, 8'h4, 64'h0);
      `CHK("fracWrite", 1'b1, reqError)
      vel_datapath_model_inst.op(3'h4, 5'h4, 8'h0, 64'h0);
      mode(vel_pkg::EW_8, vel_pkg::GF_1, 1'b1);
      rdchk("kept", 5'h4, 8'h3, 64'h43, 1'b1);
      for (int i = 4; i < 16; i++) begin
         rdchk("tailFill", 5'h4, 8'(i), 64'(vel_pkg::TAIL_FILL_BYTE), 1'b1);
      end
      vel_datapath_model_inst.op(3'h4, 5'h4, 8'h0, 64'h0);
      `CHK("tailWhole", 1'b0, wrDone)
   endtask : t_frac
   task automatic t_wide();
      mode(vel_pkg::EW_64, vel_pkg::GF_4, 1'b0);
      wr(5'h8, 8'h7, 64'h0123_4567_89ab_cdef);
      `CHK("quadWrite", 1'b1, wrDone)
      rdchk("quadRead", 5'h8, 8'h7, 64'h0123_4567_89ab_cdef, 1'b1);
      mode(vel_pkg::EW_8, vel_pkg::GF_8, 1'b0);
      wr(5'h10, 8'h7f, 64'h3c);
      `CHK("octWrite", 1'b1, wrDone)
      wr(5'h14, 8'h0, 64'h0);
      `CHK("octAlign", 1'b1, reqError)
      mode(vel_pkg::EW_8, vel_pkg::GF_1, 1'b0);
      rdchk("quadLow", 5'hb, 8'h8, 64'hef, 1'b1);
      rdchk("quadHigh", 5'hb, 8'hf, 64'h01, 1'b1);
      rdchk("octLast", 5'h17, 8'hf, 64'h3c, 1'b1);
      mode(vel_pkg::EW_16, vel_pkg::GF_EIGHTH, 1'b1);
      wr(5'h5, 8'h1, 64'h0);
      `CHK("eighthCap", 1'b1, reqError)
      wr(5'h5, 8'h0, 64'hffff_7e7e);
      rdchk("eighthRead", 5'h5, 8'h0, 64'h7e7e, 1'b1);
      mode(vel_pkg::EW_8, vel_pkg::GF_HALF, 1'b1);
      vel_datapath_model_inst.op(3'h4, 5'h5, 8'hff, 64'h0);
      `CHK("halfTail", 1'b1, wrDone)
      rdchk("halfKept", 5'h5, 8'h1, 64'h7e, 1'b1);
      rdchk("halfFill", 5'h5, 8'h8, 64'hff, 1'b0);
   endtask : t_wide
   task automatic final_report();
      $display("errors %0d checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_single();
      t_group();
      t_frac();
      t_wide();
      final_report();
   end
   initial begin
      #100000;
      error_cnt++;
      final_report();
   end
endmodule : tb_vel_layout_top
